//--- lta_pkg.sv
package lta_pkg;
  localparam int          LTA_INSTR_W     = 14;
  localparam int          LTA_DATA_W      = 8;
  // or-literal: 11 1000 kkkk kkkk
  localparam int          LTA_OR_OP_W     = 6;
  localparam logic [5:0]  LTA_OR_OP       = 6'h38;
  // load-literal: 11 00xx kkkk kkkk
  localparam int          LTA_LOAD_OP_W   = 4;
  localparam logic [3:0]  LTA_LOAD_OP     = 4'hc;
  localparam int          LTA_LIT_LSB     = 0;
  localparam logic [7:0]  LTA_ACC_RST     = 8'h00;
  localparam logic        LTA_ZERO_RST    = 1'b0;
  localparam int          LTA_EXEC_CYCLES = 1;
  localparam int          LTA_WORDS       = 1;
endpackage

//--- lta_dec_if.sv
interface lta_dec_if;
  import lta_pkg::*;
  logic [LTA_INSTR_W-1:0] instr;
  logic [LTA_DATA_W-1:0]  acc;
  logic                   is_or;
  logic                   is_load;
  logic [LTA_DATA_W-1:0]  result;
  logic                   result_zero;
  modport decoder (input instr, input acc, output is_or, output is_load,
                   output result, output result_zero);
  modport core (output instr, output acc, input is_or, input is_load,
                input result, input result_zero);
endinterface

//--- lta_decoder.sv
module lta_decoder
  import lta_pkg::*;
(
  lta_dec_if.decoder dif
);
  wire [LTA_DATA_W-1:0] literal;
  wire [LTA_DATA_W-1:0] or_value;

  assign literal = dif.instr[LTA_LIT_LSB +: LTA_DATA_W];
  assign or_value = dif.acc | literal;
  assign dif.is_or = (dif.instr[LTA_INSTR_W-1 -: LTA_OR_OP_W] == LTA_OR_OP);
  // the two don't-care bits below the load opcode are not examined
  assign dif.is_load = (dif.instr[LTA_INSTR_W-1 -: LTA_LOAD_OP_W] == LTA_LOAD_OP);
  assign dif.result = dif.is_or ? or_value : literal;
  assign dif.result_zero = (or_value == '0);
endmodule

//--- lta_literal_acc.sv
module lta_literal_acc
  import lta_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   instr_valid,
  input  wire logic [LTA_INSTR_W-1:0] instr_word,
  output logic      [LTA_DATA_W-1:0]  acc,
  output logic                        zero_flag,
  output logic                        done,
  output logic                        ignored
);
  lta_dec_if dif ();

  lta_decoder u_dec (
    .dif (dif)
  );

  wire                  take_or;
  wire                  take_load;
  wire                  write_acc;
  wire [LTA_DATA_W-1:0] next_acc;
  wire                  next_zero;
  wire                  next_done;
  wire                  next_ignored;

  assign dif.instr = instr_word;
  assign dif.acc = acc;
  assign take_or = instr_valid & dif.is_or;
  assign take_load = instr_valid & dif.is_load;
  assign write_acc = take_or | take_load;
  assign next_acc = write_acc ? dif.result : acc;
  assign next_zero = take_or ? dif.result_zero : zero_flag;
  assign next_done = write_acc;
  assign next_ignored = instr_valid & ~write_acc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= LTA_ACC_RST;
      zero_flag <= LTA_ZERO_RST;
    end else begin
      acc <= next_acc;
      zero_flag <= next_zero;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      ignored <= 1'b0;
    end else begin
      done <= next_done;
      ignored <= next_ignored;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // independent decode of the raw word, from the package encodings only
  wire                  chk_or;
  wire                  chk_load;
  wire                  chk_other;
  wire [1:0]            chk_dc;
  wire [LTA_DATA_W-1:0] chk_lit;

  assign chk_or = instr_valid && (instr_word[LTA_INSTR_W-1 -: LTA_OR_OP_W] == LTA_OR_OP);
  assign chk_load = instr_valid && (instr_word[LTA_INSTR_W-1 -: LTA_LOAD_OP_W] == LTA_LOAD_OP);
  assign chk_other = instr_valid && !chk_or && !chk_load;
  assign chk_dc = instr_word[LTA_INSTR_W-LTA_LOAD_OP_W-1 -: 2];
  assign chk_lit = instr_word[LTA_LIT_LSB +: LTA_DATA_W];

  // or-literal
  or_result_a: assert property (
    chk_or
    |=> acc == ($past(acc) | $past(chk_lit)))
    else $error("or-literal result wrong");

  or_one_cycle_a: assert property (
    chk_or
    |=> done && !ignored)
    else $error("or-literal did not complete in one cycle");

  or_zero_a: assert property (
    chk_or
    |=> zero_flag == (acc == '0))
    else $error("zero flag not tied to or result");

  or_nonzero_a: assert property (
    chk_or && chk_lit != '0
    |=> !zero_flag)
    else $error("zero flag set although literal is nonzero");

  or_zero_lit_a: assert property (
    chk_or && chk_lit == '0
    |=> $stable(acc))
    else $error("or with zero literal changed accumulator");

  or_subset_a: assert property (
    chk_or && ((chk_lit & ~acc) == '0)
    |=> $stable(acc))
    else $error("or with bits already set changed accumulator");

  or_zero_src_a: assert property (
    chk_or ##1 zero_flag
    |-> $past(acc) == '0 && $past(chk_lit) == '0)
    else $error("zero flag set from nonzero operands");

  for (genvar b = 0; b < LTA_DATA_W; b++) begin : g_or_bit
    or_bit_a: assert property (
      @(posedge clk) disable iff (!rst_n) chk_or
      |=> acc[b] == ($past(acc[b]) | $past(chk_lit[b])))
      else $error("or-literal result bit wrong");
  end

  // load-literal
  load_value_a: assert property (
    chk_load
    |=> acc == $past(chk_lit))
    else $error("load-literal value wrong");

  load_dontcare_a: assert property (
    chk_load && chk_dc != 2'h0
    |=> done && !ignored)
    else $error("load-literal with set don't-care bits not executed");

  load_keeps_z_a: assert property (
    chk_load
    |=> $stable(zero_flag))
    else $error("load-literal changed zero flag");

  load_done_a: assert property (
    chk_load
    |=> done && !ignored)
    else $error("load-literal did not complete in one cycle");

  load_max_a: assert property (
    chk_load && chk_lit == 8'hff
    |=> acc == 8'hff)
    else $error("load-literal of largest value wrong");

  // sequencing, refusals and pulses
  idle_holds_acc_a: assert property (
    !instr_valid ##1 !instr_valid
    |=> $stable(acc) && $stable(zero_flag) && !done)
    else $error("accumulator changed without instruction");

  other_op_a: assert property (
    chk_other
    |=> ignored && $stable(acc) && $stable(zero_flag))
    else $error("unrelated opcode touched accumulator");

  other_no_done_a: assert property (
    chk_other
    |=> !done)
    else $error("unrelated opcode reported as executed");

  back_to_back_a: assert property (
    chk_load ##1 chk_or
    |=> acc == ($past(chk_lit, 2) | $past(chk_lit)))
    else $error("back-to-back load then or wrong");

  or_chain_a: assert property (
    chk_or ##1 chk_or
    |=> acc == ($past(acc, 2) | $past(chk_lit, 2) | $past(chk_lit)))
    else $error("back-to-back or then or wrong");

  load_over_or_a: assert property (
    chk_or ##1 chk_load
    |=> acc == $past(chk_lit))
    else $error("back-to-back or then load wrong");

  one_outcome_a: assert property (
    instr_valid
    |=> done ^ ignored)
    else $error("instruction gave no single outcome");

  idle_no_pulse_a: assert property (
    !instr_valid
    |=> !done && !ignored)
    else $error("pulse without instruction");

  done_excl_a: assert property (
    !(done && ignored))
    else $error("done and ignored raised together");

  done_cause_a: assert property (
    done
    |-> $past(chk_or || chk_load))
    else $error("done without an executed instruction");

  ignored_cause_a: assert property (
    ignored
    |-> $past(chk_other))
    else $error("ignored without an unrelated opcode");

  acc_cause_a: assert property (
    $changed(acc)
    |-> $past(chk_or || chk_load))
    else $error("accumulator changed without an executed instruction");

  zero_cause_a: assert property (
    $changed(zero_flag)
    |-> $past(chk_or))
    else $error("zero flag changed without or-literal");

  // covers
  cov_or_zero_c: cover property (
    chk_or ##1 zero_flag);

  cov_or_nonzero_c: cover property (
    chk_or ##1 !zero_flag);

  cov_load_c: cover property (
    chk_load && chk_dc == 2'h3);

  cov_chain_c: cover property (
    chk_load ##1 chk_or);

  cov_other_c: cover property (
    chk_other ##1 ignored);
endmodule

//--- lta_prog_mem.sv
module lta_prog_mem
  import lta_pkg::*;
(
  input  wire logic [1:0]             addr,
  output logic      [LTA_INSTR_W-1:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    case (addr)
      2'h0:    word = 14'h305a;
      2'h1:    word = 14'h3835;
      2'h2:    word = 14'h3000;
      default: word = 14'h0000;
    endcase
  end
endmodule

//--- literal_to_accumulator_ops_tb_top.sv
module literal_to_accumulator_ops_tb_top;
  import lta_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 0, rst_n = 0, valid = 0, zero, done, ign;
  logic [LTA_INSTR_W-1:0] word = '0, pm_word;
  logic [LTA_DATA_W-1:0]  acc;
  logic [1:0]             pm_addr = '0;
  int                     mismatches = 0, checks = 0;
  lta_prog_mem lta_prog_mem_i (.addr(pm_addr), .word(pm_word));
  lta_literal_acc lta_literal_acc_i (.clk(clk), .rst_n(rst_n), .instr_valid(valid),
    .instr_word(word), .acc(acc), .zero_flag(zero), .done(done), .ignored(ign));
  initial forever #4 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one instruction taken, outputs judged one cycle later
  task automatic ex(input logic [13:0] w);
    @(posedge clk);
    valid <= 1'b1;
    word <= w;
    @(posedge clk);
    valid <= 1'b0;
    word <= ~w;
    #1;
  endtask
  task automatic fetch(input logic [1:0] a);
    pm_addr = a;
    #1;
    ex(pm_word);
  endtask
  task automatic t_load;
    fetch(2'h0);
    chk("acc", 8'h5a, acc);
    chk("done", 8'h01, {7'h0, done});
    chk("ignored", 8'h00, {7'h0, ign});
    ex(14'h33ff);
    chk("acc", 8'hff, acc);
    chk("zero", 8'h00, {7'h0, zero});
  endtask
  task automatic t_or;
    ex(14'h309a);
    fetch(2'h1);
    chk("acc", 8'hbf, acc);
    chk("done", 8'h01, {7'h0, done});
    chk("zero", 8'h00, {7'h0, zero});
    fetch(2'h2);
    ex(14'h3800);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h01, {7'h0, zero});
    ex(14'h3066);
    chk("zero", 8'h01, {7'h0, zero});
  endtask
  task automatic t_other;
    ex(14'h0000);
    chk("ignored", 8'h01, {7'h0, ign});
    chk("acc", 8'h66, acc);
    chk("done", 8'h00, {7'h0, done});
    chk("zero", 8'h01, {7'h0, zero});
  endtask
  // back-to-back words, one taken per edge, then an idle stretch
  task automatic t_chain;
    @(posedge clk);
    valid <= 1'b1;
    word <= 14'h3012;
    @(posedge clk);
    word <= 14'h3821;
    #1;
    chk("acc", 8'h12, acc);
    @(posedge clk);
    word <= 14'h3840;
    #1;
    chk("acc", 8'h33, acc);
    @(posedge clk);
    word <= 14'h3000;
    #1;
    chk("acc", 8'h73, acc);
    chk("zero", 8'h00, {7'h0, zero});
    @(posedge clk);
    word <= 14'h3800;
    #1;
    chk("acc", 8'h00, acc);
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk("zero", 8'h01, {7'h0, zero});
    repeat (3) @(posedge clk);
    #1;
    chk("acc", 8'h00, acc);
    chk("done", 8'h00, {7'h0, done});
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    chk("acc", LTA_ACC_RST, acc);
    rst_n <= 1'b1;
    t_load();
    t_or();
    t_other();
    t_chain();
    test_done();
  end
  initial begin
    #5000;
    mismatches++;
    test_done();
  end
endmodule
